// *** include/link_dma_pkg.sv ***
// constants and types for the parallel-link block-transfer control
package link_dma_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int unsigned RANGE_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_BYTES = 8192;
  localparam int unsigned FIFO_DEPTH = FIFO_BYTES / 2;
  localparam int unsigned FIFO_AW = 12;
  localparam int unsigned CHAIN_BYTES = 8192;
  localparam int unsigned CHAIN_DEPTH = CHAIN_BYTES / 4;
  localparam int unsigned CHAIN_AW = 11;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned BUSY_MIN_NS = 100;
  localparam int unsigned BUSY_CYCLES = (BUSY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [RANGE_W-1:0] RANGE_RST = 24'h000000;
  localparam logic [FIFO_AW:0] PTR_RST = 13'h0000;
  localparam logic READY_RST = 1'b1;

  // ****************************************
  // bridge channel set-up values written by software
  // ****************************************
  localparam logic [15:0] CH_MODE_SINGLE = 16'h1D05;
  localparam logic [15:0] CH_MODE_CHAIN = 16'h1F05;
  localparam logic [7:0] DATA_PORT_ADDR = 8'h40;
  localparam int unsigned DESC_LOC_BIT = 0;
  localparam int unsigned DESC_END_BIT = 1;
  localparam int unsigned DESC_IRQ_BIT = 2;
  localparam int unsigned DESC_DIR_BIT = 3;
  localparam int unsigned DESC_WORDS = 4;
  localparam int unsigned DESC_PCI_ADDR = 0;
  localparam int unsigned DESC_LOCAL_ADDR = 1;
  localparam int unsigned DESC_SIZE = 2;
  localparam int unsigned DESC_NEXT = 3;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_HOLD = 2'b11
  } seq_state_t;

endpackage : link_dma_pkg

// *** src/link_dma_ctrl.sv ***
// block-transfer control for the bus-mastering 16-bit parallel-link board
//
// Operation
// - bridge-side data moves only with direction, dma enable and bridge channel enabled
// - dma enable is never cleared by the block; software clears it
// - output: channel done before end-of-range; input: end-of-range first
// - output end: ready line at last cycle start, status after completion
// - input: ready status waits until the input fifo is empty
// - flag interrupts held off until output done or input drained
// - set-ready raises ready line and status; software then aborts channel
// - set-ready after partial input drains fifo before status and interrupt
// - master clear empties fifos and resets; fifo clears empty their own
// - set-ready restores ready after a start with no transfers
// - the dma request drives both bridge channels
// - descriptor holds address, size, local address and flagged next pointer
// - about 8K bytes of local memory hold chain descriptors
// - separate input and output fifos, each 8 Kbytes deep
`timescale 1ns/1ps
module link_dma_ctrl (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic RANGE_LOAD_I,
  input wire logic [23:0] RANGE_COUNT_I,
  input wire logic DMA_ENABLE_BIT_I,
  input wire logic TRANSFER_DIRECTION_IN_I,
  input wire logic CHANNEL_ENABLED_I,
  input wire logic START_PULSE_I,
  input wire logic SET_READY_PULSE_I,
  input wire logic MASTER_CLEAR_PULSE_I,
  input wire logic INPUT_FIFO_CLEAR_I,
  input wire logic OUTPUT_FIFO_CLEAR_I,
  input wire logic CYCLE_REQUEST_PULSE_I,
  input wire logic AUX_FUNCTION_TWO_PULSE_I,
  input wire logic FLAG_CLEAR_I,
  input wire logic BRIDGE_WR_I,
  input wire logic [15:0] BRIDGE_WDATA_I,
  input wire logic BRIDGE_RD_I,
  input wire logic CHAIN_WE_I,
  input wire logic [10:0] CHAIN_ADDR_I,
  input wire logic [31:0] CHAIN_WDATA_I,
  input wire logic LINK_CYCLE_RQ_I,
  input wire logic LINK_ATTENTION_I,
  input wire logic [15:0] LINK_DATA_I,
  output logic [15:0] BRIDGE_RDATA_O,
  output logic [31:0] CHAIN_RDATA_O,
  output logic DMA_REQ_CH0_O,
  output logic DMA_REQ_CH1_O,
  output logic [15:0] LINK_DATA_O,
  output logic LINK_BUSY_O,
  output logic LINK_READY_O,
  output logic LINK_AUX_FUNCTION_TWO_O,
  output logic READY_STATUS_BIT_O,
  output logic END_OF_RANGE_FLAG_O,
  output logic ATTENTION_FLAG_O,
  output logic FLAG_IRQ_O,
  output logic [23:0] RANGE_COUNT_O,
  output logic OUTPUT_FIFO_EMPTY_O,
  output logic INPUT_FIFO_EMPTY_O
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    link_dma_pkg::seq_state_t seq;
    logic [link_dma_pkg::FIFO_AW:0] out_wr;
    logic [link_dma_pkg::FIFO_AW:0] out_rd;
    logic [link_dma_pkg::FIFO_AW:0] in_wr;
    logic [link_dma_pkg::FIFO_AW:0] in_rd;
    logic [link_dma_pkg::RANGE_W-1:0] range;
    logic [7:0] busy_cnt;
    logic active;
    logic last;
    logic drain_pend;
    logic ready_line;
    logic ready_stat;
    logic eor;
    logic attn;
    logic irq;
    logic busy;
    logic aux;
    logic dma_req;
    logic out_empty;
    logic in_empty;
    logic cyc_s1;
    logic cyc_s2;
    logic cyc_prev;
    logic attn_s1;
    logic attn_s2;
    logic attn_prev;
    logic [15:0] data_s1;
    logic [15:0] data_s2;
  } state_t;

  state_t q_ff;
  state_t nxt_q;

  logic [link_dma_pkg::DATA_W-1:0] out_mem [link_dma_pkg::FIFO_DEPTH];
  logic [link_dma_pkg::DATA_W-1:0] in_mem [link_dma_pkg::FIFO_DEPTH];
  logic [31:0] chain_mem [link_dma_pkg::CHAIN_DEPTH];
  logic [15:0] link_data_ff;
  logic [15:0] rdata_ff;
  logic [31:0] chain_rdata_ff;

  logic out_push;
  logic out_pop;
  logic in_push;
  logic in_pop;
  logic out_full;
  logic in_full;
  logic out_empty;
  logic in_empty;
  logic dma_ok;
  logic cyc_edge;
  logic attn_edge;

  localparam logic [link_dma_pkg::FIFO_AW:0] PTR_ONE = 13'h0001;
  localparam logic [link_dma_pkg::RANGE_W-1:0] RANGE_ONE = 24'h000001;
  localparam logic [7:0] BUSY_LOAD = 8'(link_dma_pkg::BUSY_CYCLES - 1);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    nxt_q = q_ff;
    out_empty = (q_ff.out_wr == q_ff.out_rd);
    in_empty = (q_ff.in_wr == q_ff.in_rd);
    out_full = (q_ff.out_wr[11:0] == q_ff.out_rd[11:0]) && (q_ff.out_wr[12] != q_ff.out_rd[12]);
    in_full = (q_ff.in_wr[11:0] == q_ff.in_rd[11:0]) && (q_ff.in_wr[12] != q_ff.in_rd[12]);
    // the enable bit is only read here: ending a block never clears it
    dma_ok = DMA_ENABLE_BIT_I && CHANNEL_ENABLED_I;
    cyc_edge = (q_ff.cyc_s2 && !q_ff.cyc_prev) || CYCLE_REQUEST_PULSE_I;
    attn_edge = q_ff.attn_s2 && !q_ff.attn_prev;
    out_pop = 1'b0;
    in_push = 1'b0;
    // bridge side only moves data while enabled in the matching direction
    out_push = BRIDGE_WR_I && !out_full && dma_ok && !TRANSFER_DIRECTION_IN_I;
    in_pop = BRIDGE_RD_I && !in_empty && dma_ok && TRANSFER_DIRECTION_IN_I;

    // the first stage of each synchroniser feeds only the second
    nxt_q.cyc_s1 = LINK_CYCLE_RQ_I;
    nxt_q.cyc_s2 = q_ff.cyc_s1;
    nxt_q.cyc_prev = q_ff.cyc_s2;
    nxt_q.attn_s1 = LINK_ATTENTION_I;
    nxt_q.attn_s2 = q_ff.attn_s1;
    nxt_q.attn_prev = q_ff.attn_s2;
    nxt_q.data_s1 = LINK_DATA_I;
    nxt_q.data_s2 = q_ff.data_s1;
    nxt_q.aux = AUX_FUNCTION_TWO_PULSE_I;

    if (RANGE_LOAD_I) begin
      nxt_q.range = RANGE_COUNT_I;
    end

    // link sequencer
    case (q_ff.seq)
      link_dma_pkg::ST_IDLE: begin
        if (q_ff.active && cyc_edge) begin
          nxt_q.last = (q_ff.range == link_dma_pkg::RANGE_RST);
          if (TRANSFER_DIRECTION_IN_I) begin
            if (!in_full) begin
              in_push = 1'b1;
              nxt_q.busy = 1'b1;
              nxt_q.busy_cnt = BUSY_LOAD;
              nxt_q.seq = link_dma_pkg::ST_HOLD;
            end
          end else begin
            nxt_q.seq = link_dma_pkg::ST_FETCH;
            if (q_ff.range == link_dma_pkg::RANGE_RST) begin
              nxt_q.ready_line = 1'b1;
            end
          end
        end
      end
      link_dma_pkg::ST_FETCH: begin
        // a last cycle started on an empty fifo waits here for data
        if (!out_empty) begin
          out_pop = 1'b1;
          nxt_q.busy = 1'b1;
          nxt_q.busy_cnt = BUSY_LOAD;
          nxt_q.seq = link_dma_pkg::ST_HOLD;
        end
      end
      link_dma_pkg::ST_HOLD: begin
        if (q_ff.busy_cnt == 8'h00) begin
          nxt_q.busy = 1'b0;
          nxt_q.seq = link_dma_pkg::ST_IDLE;
          if (q_ff.last) begin
            nxt_q.active = 1'b0;
            nxt_q.eor = 1'b1;
            nxt_q.ready_line = 1'b1;
            if (TRANSFER_DIRECTION_IN_I) begin
              nxt_q.drain_pend = 1'b1;
            end else begin
              nxt_q.ready_stat = 1'b1;
            end
          end else begin
            nxt_q.range = q_ff.range - RANGE_ONE;
          end
        end else begin
          nxt_q.busy_cnt = q_ff.busy_cnt - 8'h01;
        end
      end
      default: begin
        nxt_q.seq = link_dma_pkg::ST_IDLE;
      end
    endcase

    // attention ends an idle block early, with the same drain rules
    if (attn_edge && q_ff.active && q_ff.seq == link_dma_pkg::ST_IDLE) begin
      nxt_q.active = 1'b0;
      nxt_q.ready_line = 1'b1;
      nxt_q.drain_pend = TRANSFER_DIRECTION_IN_I;
      nxt_q.ready_stat = !TRANSFER_DIRECTION_IN_I;
    end

    if (START_PULSE_I) begin
      nxt_q.active = 1'b1;
      nxt_q.ready_line = 1'b0;
      nxt_q.ready_stat = 1'b0;
      nxt_q.drain_pend = 1'b0;
      nxt_q.last = 1'b0;
    end

    if (SET_READY_PULSE_I) begin
      nxt_q.active = 1'b0;
      nxt_q.busy = 1'b0;
      nxt_q.seq = link_dma_pkg::ST_IDLE;
      nxt_q.ready_line = 1'b1;
      // after partial input the fifo drains before status goes up
      nxt_q.drain_pend = TRANSFER_DIRECTION_IN_I && !in_empty;
      nxt_q.ready_stat = !(TRANSFER_DIRECTION_IN_I && !in_empty);
    end

    if (nxt_q.drain_pend && in_empty && !in_push) begin
      nxt_q.drain_pend = 1'b0;
      nxt_q.ready_stat = 1'b1;
    end

    // a flag set in the same cycle as its clear survives
    if (FLAG_CLEAR_I) begin
      nxt_q.eor = (q_ff.seq == link_dma_pkg::ST_HOLD && q_ff.busy_cnt == 8'h00 && q_ff.last);
      nxt_q.attn = 1'b0;
    end
    if (attn_edge) begin
      nxt_q.attn = 1'b1;
    end

    // fifo pointers
    if (out_push) begin
      nxt_q.out_wr = q_ff.out_wr + PTR_ONE;
    end
    if (out_pop) begin
      nxt_q.out_rd = q_ff.out_rd + PTR_ONE;
    end
    if (in_push) begin
      nxt_q.in_wr = q_ff.in_wr + PTR_ONE;
    end
    if (in_pop) begin
      nxt_q.in_rd = q_ff.in_rd + PTR_ONE;
    end
    if (OUTPUT_FIFO_CLEAR_I) begin
      nxt_q.out_wr = link_dma_pkg::PTR_RST;
      nxt_q.out_rd = link_dma_pkg::PTR_RST;
    end
    if (INPUT_FIFO_CLEAR_I) begin
      nxt_q.in_wr = link_dma_pkg::PTR_RST;
      nxt_q.in_rd = link_dma_pkg::PTR_RST;
    end

    // request toward the bridge: room for output, or input data to drain
    nxt_q.dma_req = dma_ok && ((!TRANSFER_DIRECTION_IN_I && q_ff.active && !out_full)
                              || (TRANSFER_DIRECTION_IN_I && (q_ff.active || q_ff.drain_pend)
                                  && !in_empty));
    // flag interrupts only once the block is truly finished
    nxt_q.irq = (nxt_q.eor || nxt_q.attn) && nxt_q.ready_stat;

    if (MASTER_CLEAR_PULSE_I) begin
      nxt_q.seq = link_dma_pkg::ST_IDLE;
      nxt_q.out_wr = link_dma_pkg::PTR_RST;
      nxt_q.out_rd = link_dma_pkg::PTR_RST;
      nxt_q.in_wr = link_dma_pkg::PTR_RST;
      nxt_q.in_rd = link_dma_pkg::PTR_RST;
      nxt_q.range = link_dma_pkg::RANGE_RST;
      nxt_q.active = 1'b0;
      nxt_q.last = 1'b0;
      nxt_q.drain_pend = 1'b0;
      nxt_q.busy = 1'b0;
      nxt_q.busy_cnt = 8'h00;
      nxt_q.ready_line = link_dma_pkg::READY_RST;
      nxt_q.ready_stat = link_dma_pkg::READY_RST;
      nxt_q.eor = 1'b0;
      nxt_q.attn = 1'b0;
      nxt_q.irq = 1'b0;
      nxt_q.dma_req = 1'b0;
    end

    nxt_q.out_empty = (nxt_q.out_wr == nxt_q.out_rd);
    nxt_q.in_empty = (nxt_q.in_wr == nxt_q.in_rd);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      q_ff <= '0;
      q_ff.ready_line <= link_dma_pkg::READY_RST;
      q_ff.ready_stat <= link_dma_pkg::READY_RST;
      q_ff.out_empty <= 1'b1;
      q_ff.in_empty <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // fifo and chain memories
  // ****************************************
  // arrays are not reset: clearing the pointers is what discards contents
  always_ff @(posedge SYS_CLK_I) begin
    if (out_push) begin
      out_mem[q_ff.out_wr[11:0]] <= BRIDGE_WDATA_I;
    end
    if (in_push) begin
      in_mem[q_ff.in_wr[11:0]] <= q_ff.data_s2;
    end
    if (CHAIN_WE_I) begin
      chain_mem[CHAIN_ADDR_I] <= CHAIN_WDATA_I;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      link_data_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      chain_rdata_ff <= 32'h00000000;
    end else begin
      if (out_pop) begin
        link_data_ff <= out_mem[q_ff.out_rd[11:0]];
      end
      // a read past the end returns a filler word so paired reads complete
      if (BRIDGE_RD_I) begin
        rdata_ff <= in_pop ? in_mem[q_ff.in_rd[11:0]] : 16'h0000;
      end
      chain_rdata_ff <= chain_mem[CHAIN_ADDR_I];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign BRIDGE_RDATA_O = rdata_ff;
  assign CHAIN_RDATA_O = chain_rdata_ff;
  assign DMA_REQ_CH0_O = q_ff.dma_req;
  assign DMA_REQ_CH1_O = q_ff.dma_req;
  assign LINK_DATA_O = link_data_ff;
  assign LINK_BUSY_O = q_ff.busy;
  assign LINK_READY_O = q_ff.ready_line;
  assign LINK_AUX_FUNCTION_TWO_O = q_ff.aux;
  assign READY_STATUS_BIT_O = q_ff.ready_stat;
  assign END_OF_RANGE_FLAG_O = q_ff.eor;
  assign ATTENTION_FLAG_O = q_ff.attn;
  assign FLAG_IRQ_O = q_ff.irq;
  assign RANGE_COUNT_O = q_ff.range;
  assign OUTPUT_FIFO_EMPTY_O = q_ff.out_empty;
  assign INPUT_FIFO_EMPTY_O = q_ff.in_empty;

endmodule : link_dma_ctrl

// *** sim/link_dma_ctrl_sva.sv ***
// assertion checker for the block-transfer control ports
`timescale 1ns/1ps
module link_dma_ctrl_sva (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic DMA_ENABLE_BIT_I,
  input wire logic TRANSFER_DIRECTION_IN_I,
  input wire logic CHANNEL_ENABLED_I,
  input wire logic START_PULSE_I,
  input wire logic SET_READY_PULSE_I,
  input wire logic MASTER_CLEAR_PULSE_I,
  input wire logic AUX_FUNCTION_TWO_PULSE_I,
  input wire logic DMA_REQ_CH0_O,
  input wire logic DMA_REQ_CH1_O,
  input wire logic LINK_BUSY_O,
  input wire logic LINK_READY_O,
  input wire logic LINK_AUX_FUNCTION_TWO_O,
  input wire logic READY_STATUS_BIT_O,
  input wire logic END_OF_RANGE_FLAG_O,
  input wire logic ATTENTION_FLAG_O,
  input wire logic FLAG_IRQ_O,
  input wire logic OUTPUT_FIFO_EMPTY_O,
  input wire logic INPUT_FIFO_EMPTY_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ****************************************
  // busy length counter
  // ****************************************
  logic [7:0] busy_cnt_ff;
  always_ff @(posedge SYS_CLK_I) begin
    busy_cnt_ff <= (SYS_RST_I || !LINK_BUSY_O) ? 8'h00 : busy_cnt_ff + 8'h01;
  end
  a_req_twin: assert property (DMA_REQ_CH0_O == DMA_REQ_CH1_O)
    else $error("dma requests differ");
  a_req_gated: assert property (DMA_REQ_CH0_O |-> $past(DMA_ENABLE_BIT_I) && $past(CHANNEL_ENABLED_I))
    else $error("dma request without enable");
  a_start_drops: assert property (START_PULSE_I && !SET_READY_PULSE_I && !MASTER_CLEAR_PULSE_I
    |=> !LINK_READY_O && !READY_STATUS_BIT_O)
    else $error("start did not drop ready");
  a_setrdy_raise: assert property (SET_READY_PULSE_I && !MASTER_CLEAR_PULSE_I
    && !TRANSFER_DIRECTION_IN_I |=> LINK_READY_O && READY_STATUS_BIT_O)
    else $error("set-ready did not raise ready");
  a_clear_empties: assert property (MASTER_CLEAR_PULSE_I
    |=> OUTPUT_FIFO_EMPTY_O && INPUT_FIFO_EMPTY_O && LINK_READY_O && READY_STATUS_BIT_O)
    else $error("master clear incomplete");
  // the interrupt is registered together with the flags and the status bit
  a_irq_held: assert property (FLAG_IRQ_O
    == (READY_STATUS_BIT_O && (END_OF_RANGE_FLAG_O || ATTENTION_FLAG_O)))
    else $error("flag interrupt not held off");
  a_in_drained: assert property ($rose(READY_STATUS_BIT_O) && TRANSFER_DIRECTION_IN_I
    |-> INPUT_FIFO_EMPTY_O)
    else $error("status set with input data left");
  // an abort by set-ready or master clear may cut a cycle short: not a block end
  a_out_line_first: assert property ($fell(LINK_BUSY_O) && !TRANSFER_DIRECTION_IN_I
    && $rose(READY_STATUS_BIT_O) && !$past(SET_READY_PULSE_I) && !$past(MASTER_CLEAR_PULSE_I)
    |-> $past(LINK_READY_O, 3))
    else $error("ready line late on last output");
  a_busy_len: assert property ($fell(LINK_BUSY_O) && !$past(SET_READY_PULSE_I)
    && !$past(MASTER_CLEAR_PULSE_I) |-> busy_cnt_ff == link_dma_pkg::BUSY_CYCLES)
    else $error("busy length wrong");
  a_aux_echo: assert property (AUX_FUNCTION_TWO_PULSE_I
    |=> LINK_AUX_FUNCTION_TWO_O ##1 !LINK_AUX_FUNCTION_TWO_O)
    else $error("aux pulse not echoed once");
endmodule : link_dma_ctrl_sva

bind link_dma_ctrl link_dma_ctrl_sva i_link_dma_ctrl_sva (
  .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .DMA_ENABLE_BIT_I(DMA_ENABLE_BIT_I),
  .TRANSFER_DIRECTION_IN_I(TRANSFER_DIRECTION_IN_I), .CHANNEL_ENABLED_I(CHANNEL_ENABLED_I),
  .START_PULSE_I(START_PULSE_I), .SET_READY_PULSE_I(SET_READY_PULSE_I),
  .MASTER_CLEAR_PULSE_I(MASTER_CLEAR_PULSE_I), .AUX_FUNCTION_TWO_PULSE_I(AUX_FUNCTION_TWO_PULSE_I),
  .DMA_REQ_CH0_O(DMA_REQ_CH0_O), .DMA_REQ_CH1_O(DMA_REQ_CH1_O), .LINK_BUSY_O(LINK_BUSY_O),
  .LINK_READY_O(LINK_READY_O), .LINK_AUX_FUNCTION_TWO_O(LINK_AUX_FUNCTION_TWO_O),
  .READY_STATUS_BIT_O(READY_STATUS_BIT_O), .END_OF_RANGE_FLAG_O(END_OF_RANGE_FLAG_O),
  .ATTENTION_FLAG_O(ATTENTION_FLAG_O), .FLAG_IRQ_O(FLAG_IRQ_O),
  .OUTPUT_FIFO_EMPTY_O(OUTPUT_FIFO_EMPTY_O), .INPUT_FIFO_EMPTY_O(INPUT_FIFO_EMPTY_O)
);

// *** sim/link_peer.sv ***
// attached parallel device model: one cycle request per word
`timescale 1ns/1ps
module link_peer (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [15:0] word_i,
  input wire logic busy_i,
  input wire logic [15:0] dout_i,
  output logic rq_o = 1'b0,
  output logic [15:0] din_o = 16'h0000,
  output logic [15:0] seen_o = 16'h0000
);
  logic busy_d = 1'b0;
  int hold = 0;
  always @(posedge clk_i) begin
    busy_d <= busy_i;
    if (go_i) begin
      din_o <= word_i;
      rq_o <= 1'b1;
      hold <= 6;
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else if (hold == 1) begin
      hold <= 0;
      rq_o <= 1'b0;
    end
    if (busy_d && !busy_i) begin
      seen_o <= dout_i;
      // data lines are undriven after the cycle: show something stale-proof
      din_o <= ~din_o;
    end
  end
endmodule : link_peer

// *** sim/link_dma_ctrl_tb.sv ***
// self-checking bench for the block-transfer control
`timescale 1ns/1ps
module link_dma_ctrl_tb;
  localparam int LD = 0, GO = 1, SR = 2, MC = 3, IFC = 4, OFC = 5;
  localparam int CY = 6, AX = 7, FC = 8, WR = 9, RD = 10, CWE = 11;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] pls = 12'h000;
  logic [23:0] rng = 24'h000000;
  logic en = 1'b0, dir = 1'b0, chen = 1'b0, attn = 1'b0, go = 1'b0;
  logic [15:0] wd = 16'h0000, word = 16'h0000;
  logic [10:0] caddr = 11'h000;
  logic [31:0] cwd = 32'h00000000;
  logic [15:0] rd, ldo, ldi, seen;
  logic [31:0] crd;
  logic [23:0] rcnt;
  logic [1:0] mid;
  logic req0, req1, busy, lrdy, aux, stat, eor, att, irq, ofe, ife, rq;
  int fails = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  link_dma_ctrl i_link_dma_ctrl (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .RANGE_LOAD_I(pls[LD]), .RANGE_COUNT_I(rng),
    .DMA_ENABLE_BIT_I(en), .TRANSFER_DIRECTION_IN_I(dir), .CHANNEL_ENABLED_I(chen),
    .START_PULSE_I(pls[GO]), .SET_READY_PULSE_I(pls[SR]), .MASTER_CLEAR_PULSE_I(pls[MC]),
    .INPUT_FIFO_CLEAR_I(pls[IFC]), .OUTPUT_FIFO_CLEAR_I(pls[OFC]), .CYCLE_REQUEST_PULSE_I(pls[CY]),
    .AUX_FUNCTION_TWO_PULSE_I(pls[AX]), .FLAG_CLEAR_I(pls[FC]), .BRIDGE_WR_I(pls[WR]),
    .BRIDGE_WDATA_I(wd), .BRIDGE_RD_I(pls[RD]), .CHAIN_WE_I(pls[CWE]), .CHAIN_ADDR_I(caddr),
    .CHAIN_WDATA_I(cwd), .LINK_CYCLE_RQ_I(rq), .LINK_ATTENTION_I(attn), .LINK_DATA_I(ldi),
    .BRIDGE_RDATA_O(rd), .CHAIN_RDATA_O(crd), .DMA_REQ_CH0_O(req0), .DMA_REQ_CH1_O(req1),
    .LINK_DATA_O(ldo), .LINK_BUSY_O(busy), .LINK_READY_O(lrdy), .LINK_AUX_FUNCTION_TWO_O(aux),
    .READY_STATUS_BIT_O(stat), .END_OF_RANGE_FLAG_O(eor), .ATTENTION_FLAG_O(att),
    .FLAG_IRQ_O(irq), .RANGE_COUNT_O(rcnt), .OUTPUT_FIFO_EMPTY_O(ofe), .INPUT_FIFO_EMPTY_O(ife)
  );
  link_peer i_link_peer (
    .clk_i(clk), .go_i(go), .word_i(word), .busy_i(busy), .dout_i(ldo),
    .rq_o(rq), .din_o(ldi), .seen_o(seen)
  );
  task print_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bound(input logic bad);
    if (bad) begin
      fails++;
      print_verdict();
    end
  endtask : bound
  task pulse(input int b);
    @(negedge clk) pls[b] = 1'b1;
    @(negedge clk) pls[b] = 1'b0;
  endtask : pulse
  task bw(input logic [15:0] d);
    wd = d;
    pulse(WR);
  endtask : bw
  task brd(input logic [15:0] e);
    pulse(RD);
    chk(rd, e);
  endtask : brd
  // sw selects the software cycle request instead of the device pin
  task xfer(input logic [15:0] w, input logic sw);
    int n;
    word = w;
    @(negedge clk);
    if (sw) pls[CY] = 1'b1;
    else go = 1'b1;
    @(negedge clk) go = 1'b0;
    pls[CY] = 1'b0;
    for (n = 0; n < 64 && busy !== 1'b1; n++) @(negedge clk);
    bound(busy !== 1'b1);
    mid = {lrdy, stat};
    for (n = 0; n < 64 && busy !== 1'b0; n++) @(negedge clk);
    bound(busy !== 1'b0);
    // the peer latches the output word one edge after busy falls
    @(negedge clk);
  endtask : xfer
  task wait_stat();
    int n;
    for (n = 0; n < 64 && stat !== 1'b1; n++) @(negedge clk);
    bound(stat !== 1'b1);
  endtask : wait_stat
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk({lrdy, stat, ofe, ife, req0, eor, att, irq}, 8'hF0);
    chk(rcnt, 24'h000000);
    rng = 24'h000001;
    pulse(LD);
    en = 1'b1;
    chen = 1'b1;
    pulse(GO);
    chk({lrdy, stat}, 2'h0);
    @(negedge clk);
    chk({req0, req1}, 2'h3);
    bw(16'hA5C3);
    bw(16'h5A3C);
    xfer(16'h0000, 1'b0);
    chk(seen, 16'hA5C3);
    chk({rcnt, stat}, 25'h0000000);
    xfer(16'h0000, 1'b1);
    chk(mid, 2'h2);
    chk({seen, stat, eor}, 18'h168F3);
    @(negedge clk);
    chk(irq, 1'b1);
    en = 1'b0;
    pulse(FC);
    pulse(LD);
    dir = 1'b1;
    en = 1'b1;
    pulse(GO);
    xfer(16'h1234, 1'b0);
    xfer(16'hFEDC, 1'b0);
    chk({eor, stat, irq, ife, req0}, 5'h11);
    brd(16'h1234);
    brd(16'hFEDC);
    wait_stat();
    chk(ife, 1'b1);
    @(negedge clk);
    chk(irq, 1'b1);
    en = 1'b0;
    pulse(FC);
    en = 1'b1;
    rng = 24'h000003;
    pulse(LD);
    pulse(GO);
    xfer(16'h0F0F, 1'b0);
    pulse(SR);
    chk({lrdy, stat, irq}, 3'h4);
    brd(16'h0F0F);
    brd(16'h0000);
    wait_stat();
    chk(rcnt, 24'h000002);
    en = 1'b0;
    dir = 1'b0;
    pulse(GO);
    chk({lrdy, stat, req0}, 3'h0);
    pulse(SR);
    chk({lrdy, stat}, 2'h3);
    attn = 1'b1;
    repeat (6) @(negedge clk);
    chk({att, irq}, 2'h3);
    attn = 1'b0;
    pulse(FC);
    en = 1'b1;
    pulse(GO);
    bw(16'h1111);
    chk(ofe, 1'b0);
    pulse(OFC);
    chk({ofe, ife}, 2'h3);
    bw(16'h2222);
    pulse(MC);
    chk({ofe, lrdy, stat, rcnt}, 27'h7000000);
    dir = 1'b1;
    pulse(GO);
    xfer(16'h3333, 1'b0);
    chk(ife, 1'b0);
    pulse(IFC);
    chk({ife, ofe}, 2'h3);
    pulse(MC);
    pulse(AX);
    chk(aux, 1'b1);
    chk({link_dma_pkg::CH_MODE_SINGLE, link_dma_pkg::CH_MODE_CHAIN}, 32'h1D051F05);
    chk(link_dma_pkg::DATA_PORT_ADDR, 8'h40);
    // next-pointer word of a descriptor on a four-word boundary
    caddr = 11'h7FF;
    cwd = 32'h0000000B;
    pulse(CWE);
    @(negedge clk);
    chk(crd, 32'h0000000B);
    print_verdict();
  end
endmodule : link_dma_ctrl_tb
